// ==== rtl/e1rs_axil.sv ====
// Purpose: AXI4-Lite slave front end for the status registers
// Assumes: one write and one read in flight at most
// Notes:   address and data taken in either order; answer one cycle after
module e1rs_axil (
    input  wire logic                aclk,          // system clock
    input  wire logic                aresetn,       // sync reset, low
    input  wire e1rs_pkg::e1rs_addr_t s_axi_awaddr, // write address
    input  wire logic                s_axi_awvalid, // write address valid
    output logic                     s_axi_awready, // write address ready
    input  wire logic [31:0]         s_axi_wdata,   // write data
    input  wire logic [3:0]          s_axi_wstrb,   // write byte lanes
    input  wire logic                s_axi_wvalid,  // write data valid
    output logic                     s_axi_wready,  // write data ready
    output logic [1:0]               s_axi_bresp,   // write answer
    output logic                     s_axi_bvalid,  // write answer valid
    input  wire logic                s_axi_bready,  // write answer ready
    input  wire e1rs_pkg::e1rs_addr_t s_axi_araddr, // read address
    input  wire logic                s_axi_arvalid, // read address valid
    output logic                     s_axi_arready, // read address ready
    output logic [31:0]              s_axi_rdata,   // read data
    output logic [1:0]               s_axi_rresp,   // read answer
    output logic                     s_axi_rvalid,  // read answer valid
    input  wire logic                s_axi_rready,  // read answer ready
    output logic                     wr_en,         // register write pulse
    output e1rs_pkg::e1rs_addr_t     wr_addr,       // register write addr
    output e1rs_pkg::e1rs_byte_t     wr_data,       // register write data
    output logic                     wr_lane0,      // low lane enabled
    input  wire logic                wr_hit,        // write addr mapped
    output logic                     rd_en,         // register read pulse
    output e1rs_pkg::e1rs_addr_t     rd_addr,       // register read addr
    input  wire e1rs_pkg::e1rs_byte_t rd_data,      // register read data
    input  wire logic                rd_hit         // read addr mapped
);
    import e1rs_pkg::*;
    `include "e1rs_regs.svh"

    localparam e1rs_axil_st_t RST = '{awready: 1'b1, wready: 1'b1,
                                      arready: 1'b1, default: '0};

    e1rs_axil_st_t st;       // registered state
    e1rs_axil_st_t next_st;  // next state

    // both halves held and no answer pending: do the write
    assign wr_en    = !st.awready && !st.wready && !st.bvalid;
    assign wr_addr  = st.waddr;
    assign wr_data  = st.wdata;
    assign wr_lane0 = st.wstrb0;
    // a read is served at the edge it is accepted
    assign rd_en    = s_axi_arvalid && st.arready;
    assign rd_addr  = s_axi_araddr;

    // channel handshakes
    always_comb begin
        next_st = st;
        if (s_axi_awvalid && st.awready) begin
            next_st.awready = 1'b0;
            next_st.waddr   = s_axi_awaddr;
        end
        if (s_axi_wvalid && st.wready) begin
            next_st.wready = 1'b0;
            next_st.wdata  = s_axi_wdata[7:0];
            next_st.wstrb0 = s_axi_wstrb[0];
        end
        if (wr_en) begin
            next_st.bvalid = 1'b1;
            next_st.bresp  = wr_hit ? `E1RS_RESP_OKAY : `E1RS_RESP_SLVERR;
        end
        // slots reopen only once the answer is taken
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid  = 1'b0;
            next_st.awready = 1'b1;
            next_st.wready  = 1'b1;
        end
        if (rd_en) begin
            next_st.arready = 1'b0;
            next_st.rvalid  = 1'b1;
            next_st.rdata   = {24'h000000, rd_hit ? rd_data : 8'h00};
            next_st.rresp   = rd_hit ? `E1RS_RESP_OKAY : `E1RS_RESP_SLVERR;
        end
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid  = 1'b0;
            next_st.arready = 1'b1;
        end
    end

    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= RST;
        end else begin
            st <= next_st;
        end
    end

    assign s_axi_awready = st.awready;
    assign s_axi_wready  = st.wready;
    assign s_axi_bvalid  = st.bvalid;
    assign s_axi_bresp   = st.bresp;
    assign s_axi_arready = st.arready;
    assign s_axi_rvalid  = st.rvalid;
    assign s_axi_rdata   = st.rdata;
    assign s_axi_rresp   = st.rresp;

    chk_bvalid_holds: assert property (@(posedge aclk)
        disable iff (!aresetn)
        st.bvalid && !s_axi_bready |=> st.bvalid && $stable(st.bresp))
        else $error("write answer dropped before taken");
    chk_rvalid_holds: assert property (@(posedge aclk)
        disable iff (!aresetn)
        st.rvalid && !s_axi_rready |=> st.rvalid && $stable(st.rdata))
        else $error("read answer dropped before taken");
    chk_write_answers: assert property (@(posedge aclk)
        disable iff (!aresetn)
        wr_en |=> st.bvalid ##0 !wr_en)
        else $error("write not answered next cycle");
endmodule

// ==== rtl/e1rs_mf_lock.sv ====
// Purpose: multiframe lock tracker fed by alignment-word verdicts
// Assumes: one strobe per received alignment signal, same clock
// Notes:   a loss count of zero behaves as one
module e1rs_mf_lock (
    input  wire logic               aclk,        // system clock
    input  wire logic               aresetn,     // sync reset, low
    input  wire logic               align_stb,   // alignment word seen
    input  wire logic               align_ok,    // word was correct
    input  wire logic               decl_two,    // need two good in a row
    input  wire e1rs_pkg::e1rs_cnt_t loss_count, // errors to lose lock
    output logic                    locked       // lock declared
);
    import e1rs_pkg::*;

    e1rs_lock_st_t st;       // registered state
    e1rs_lock_st_t next_st;  // next state

    // lock declaration and loss
    always_comb begin
        e1rs_cnt_t limit;
        e1rs_cnt_t inc;
        limit   = (loss_count == 4'h0) ? 4'h1 : loss_count;
        inc     = st.bad_cnt + 4'h1;
        next_st = st;
        if (align_stb) begin
            if (align_ok) begin
                next_st.bad_cnt = 4'h0;
                if (!st.locked) begin
                    // declaration criterion chosen by software
                    if (decl_two && !st.good_seen) begin
                        next_st.good_seen = 1'b1;
                    end else begin
                        next_st.locked    = 1'b1;
                        next_st.good_seen = 1'b0;
                    end
                end
            end else begin
                next_st.good_seen = 1'b0;
                // errors only count toward a loss while locked
                if (st.locked) begin
                    if (inc >= limit) begin
                        next_st.locked  = 1'b0;
                        next_st.bad_cnt = 4'h0;
                    end else begin
                        next_st.bad_cnt = inc;
                    end
                end
            end
        end
    end

    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign locked = st.locked;

    chk_loss_needs_error: assert property (@(posedge aclk)
        disable iff (!aresetn)
        $fell(st.locked) |-> $past(align_stb && !align_ok))
        else $error("lock lost without an errored alignment");
    chk_lock_needs_good: assert property (@(posedge aclk)
        disable iff (!aresetn)
        $rose(st.locked) |-> $past(align_stb && align_ok))
        else $error("lock declared without a good alignment");
    chk_two_good_decl: assert property (@(posedge aclk)
        disable iff (!aresetn)
        $rose(st.locked) && $past(decl_two) |-> $past(st.good_seen))
        else $error("lock declared after a single good alignment");
endmodule

// ==== rtl/e1rs_pkg.sv ====
// Purpose: shared types of the receive sync and slip status block
// Assumes: constants live in e1rs_regs.svh
// Notes:   state records are packed so each module holds one register
package e1rs_pkg;
    typedef logic [3:0]  e1rs_addr_t;   // register byte address
    typedef logic [7:0]  e1rs_byte_t;   // register data width
    typedef logic [3:0]  e1rs_cnt_t;    // consecutive error count

    // multiframe lock tracker state
    typedef struct packed {
        logic      locked;              // lock declared
        logic      good_seen;           // first good alignment seen
        e1rs_cnt_t bad_cnt;             // consecutive errored alignments
    } e1rs_lock_st_t;

    // bus slave state
    typedef struct packed {
        logic        awready;           // write address slot free
        logic        wready;            // write data slot free
        logic        arready;           // read slot free
        logic        bvalid;            // write answer pending
        logic        rvalid;            // read answer pending
        logic [1:0]  bresp;             // write answer code
        logic [1:0]  rresp;             // read answer code
        e1rs_addr_t  waddr;             // held write address
        e1rs_byte_t  wdata;             // held write data, low byte
        logic        wstrb0;            // low byte lane enabled
        logic [31:0] rdata;             // held read data
    } e1rs_axil_st_t;

    // top level state
    typedef struct packed {
        logic       rx_full;            // sticky slip-buffer-full event
        logic       mask_full;          // interrupt mask for that event
        logic [1:0] fsel;               // framing select
        e1rs_byte_t fctl;               // framing control
        logic       drop;               // frame discard pulse
        logic       irq;                // interrupt level
    } e1rs_top_st_t;
endpackage

// ==== rtl/e1rs_regs.svh ====
// Purpose: register offsets, field positions and reset values of the
//          receive sync and slip status block
// Assumes: byte addresses on a 32-bit AXI4-Lite slave, one word each
// Notes:   included by bare name; definitions only
`ifndef E1RS_REGS_SVH
`define E1RS_REGS_SVH

// word offsets (byte addresses)
`define E1RS_OFF_STATUS   4'h0
`define E1RS_OFF_MASK     4'h4
`define E1RS_OFF_FSEL     4'h8
`define E1RS_OFF_FCTL     4'hC

// status and mask field positions
`define E1RS_BIT_CAS_LOCK 4
`define E1RS_BIT_CRC_LOCK 3
`define E1RS_BIT_RX_FULL  2

// framing select fields
`define E1RS_BIT_CAS_DECL 0
`define E1RS_BIT_CRC_DECL 1

// framing control fields: two consecutive-error counts
`define E1RS_CAS_CNT_LSB  0
`define E1RS_CAS_CNT_MSB  3
`define E1RS_CRC_CNT_LSB  4
`define E1RS_CRC_CNT_MSB  7

// reset values
`define E1RS_RST_MASK     1'h0
`define E1RS_RST_FSEL     2'h0
`define E1RS_RST_FCTL     8'h22

// bus answers
`define E1RS_RESP_OKAY    2'h0
`define E1RS_RESP_SLVERR  2'h2

`endif

// ==== rtl/e1rs_top.sv ====
// Purpose: receive multiframe lock and slip-buffer-full status bank
// Assumes: framer verdicts and slip buffer events arrive on aclk
// Notes:   registers reached over AXI4-Lite; one level interrupt out
//
// Local design decisions: the AXI4-Lite register port and the address map.
module e1rs_top (
    input  wire logic                aclk,             // 100 MHz clock
    input  wire logic                aresetn,          // sync reset, low
    input  wire e1rs_pkg::e1rs_addr_t s_axi_awaddr,    // write address
    input  wire logic                s_axi_awvalid,    // write addr valid
    output logic                     s_axi_awready,    // write addr ready
    input  wire logic [31:0]         s_axi_wdata,      // write data
    input  wire logic [3:0]          s_axi_wstrb,      // write byte lanes
    input  wire logic                s_axi_wvalid,     // write data valid
    output logic                     s_axi_wready,     // write data ready
    output logic [1:0]               s_axi_bresp,      // write answer
    output logic                     s_axi_bvalid,     // write answer valid
    input  wire logic                s_axi_bready,     // write answer ready
    input  wire e1rs_pkg::e1rs_addr_t s_axi_araddr,    // read address
    input  wire logic                s_axi_arvalid,    // read addr valid
    output logic                     s_axi_arready,    // read addr ready
    output logic [31:0]              s_axi_rdata,      // read data
    output logic [1:0]               s_axi_rresp,      // read answer
    output logic                     s_axi_rvalid,     // read answer valid
    input  wire logic                s_axi_rready,     // read answer ready
    input  wire logic                cas_align_stb,    // CAS word received
    input  wire logic                cas_align_ok,     // CAS word correct
    input  wire logic                crc_align_stb,    // CRC word received
    input  wire logic                crc_align_ok,     // CRC word correct
    input  wire logic                rx_slip_buf_full, // slip buffer full
    input  wire logic                rx_slip_wr,       // slip buffer write
    output logic                     rx_slip_drop,     // discard one frame
    output logic                     cas_mf_lock,      // CAS lock level
    output logic                     crc_mf_lock_flag, // CRC lock level
    output logic                     irq               // interrupt, high
);
    import e1rs_pkg::*;
    `include "e1rs_regs.svh"

    e1rs_top_st_t st;        // registered state
    e1rs_top_st_t next_st;   // next state

    logic       wr_en;       // register write pulse
    e1rs_addr_t wr_addr;     // register write address
    e1rs_byte_t wr_data;     // register write data
    logic       wr_lane0;    // low byte lane enabled
    logic       wr_hit;      // write address mapped
    logic       rd_en;       // register read pulse
    e1rs_addr_t rd_addr;     // register read address
    e1rs_byte_t rd_data;     // read mux output
    logic       rd_hit;      // read address mapped
    logic       slip_event;  // full buffer written
    logic       status_rd;   // status register read this cycle
    logic       status_clr;  // write-one clear of the sticky bit
    logic       cas_lock;    // CAS tracker output
    logic       crc_lock;    // CRC tracker output

    // true when the address names a mapped register
    function automatic logic is_mapped(input e1rs_addr_t a);
        is_mapped = (a == `E1RS_OFF_STATUS) || (a == `E1RS_OFF_MASK) ||
                    (a == `E1RS_OFF_FSEL) || (a == `E1RS_OFF_FCTL);
    endfunction

    // bus slave; all answers are registered inside it
    e1rs_axil u_axil (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .wr_en         (wr_en),
        .wr_addr       (wr_addr),
        .wr_data       (wr_data),
        .wr_lane0      (wr_lane0),
        .wr_hit        (wr_hit),
        .rd_en         (rd_en),
        .rd_addr       (rd_addr),
        .rd_data       (rd_data),
        .rd_hit        (rd_hit)
    );

    // CAS multiframe tracker: criterion and error count from software
    e1rs_mf_lock u_cas_lock (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .align_stb  (cas_align_stb),
        .align_ok   (cas_align_ok),
        .decl_two   (st.fsel[`E1RS_BIT_CAS_DECL]),
        .loss_count (st.fctl[`E1RS_CAS_CNT_MSB:`E1RS_CAS_CNT_LSB]),
        .locked     (cas_lock)
    );

    // CRC multiframe tracker
    e1rs_mf_lock u_crc_lock (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .align_stb  (crc_align_stb),
        .align_ok   (crc_align_ok),
        .decl_two   (st.fsel[`E1RS_BIT_CRC_DECL]),
        .loss_count (st.fctl[`E1RS_CRC_CNT_MSB:`E1RS_CRC_CNT_LSB]),
        .locked     (crc_lock)
    );

    assign wr_hit = is_mapped(wr_addr);
    assign rd_hit = is_mapped(rd_addr);

    // read mux; lock bits are live, not latched
    always_comb begin
        rd_data = 8'h00;
        unique case (rd_addr)
            `E1RS_OFF_STATUS: begin
                rd_data[`E1RS_BIT_CAS_LOCK] = cas_lock;
                rd_data[`E1RS_BIT_CRC_LOCK] = crc_lock;
                rd_data[`E1RS_BIT_RX_FULL]  = st.rx_full;
            end
            `E1RS_OFF_MASK: begin
                rd_data[`E1RS_BIT_RX_FULL] = st.mask_full;
            end
            `E1RS_OFF_FSEL: begin
                rd_data[1:0] = st.fsel;
            end
            `E1RS_OFF_FCTL: begin
                rd_data = st.fctl;
            end
            default: begin
                rd_data = 8'h00;   // unmapped reads as zero
            end
        endcase
    end

    assign slip_event = rx_slip_buf_full && rx_slip_wr;
    assign status_rd  = rd_en && (rd_addr == `E1RS_OFF_STATUS);
    assign status_clr = wr_en && wr_lane0 &&
                        (wr_addr == `E1RS_OFF_STATUS) &&
                        wr_data[`E1RS_BIT_RX_FULL];

    // register writes, sticky event and interrupt
    always_comb begin
        next_st      = st;
        // one-cycle discard request to the slip buffer
        next_st.drop = slip_event;
        if (wr_en && wr_lane0) begin
            // writes to the lock bits are ignored: they are read-only
            unique case (wr_addr)
                `E1RS_OFF_MASK: begin
                    next_st.mask_full = wr_data[`E1RS_BIT_RX_FULL];
                end
                `E1RS_OFF_FSEL: begin
                    next_st.fsel = wr_data[1:0];
                end
                `E1RS_OFF_FCTL: begin
                    next_st.fctl = wr_data;
                end
                default: begin
                    next_st.fctl = st.fctl;   // status or unmapped
                end
            endcase
        end
        // the read returns the old value, so a set in the same cycle
        // must survive the clear or the event would go unseen
        next_st.rx_full = (st.rx_full && !status_rd && !status_clr)
                          || slip_event;
        // level interrupt from the registered next value
        next_st.irq = next_st.rx_full && next_st.mask_full;
    end

    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st           <= '0;
            st.mask_full <= `E1RS_RST_MASK;
            st.fsel      <= `E1RS_RST_FSEL;
            st.fctl      <= `E1RS_RST_FCTL;
        end else begin
            st <= next_st;
        end
    end

    assign rx_slip_drop     = st.drop;
    assign irq              = st.irq;
    assign cas_mf_lock      = cas_lock;
    assign crc_mf_lock_flag = crc_lock;

    chk_drop_on_full: assert property (@(posedge aclk)
        disable iff (!aresetn)
        slip_event |=> rx_slip_drop ##1 (rx_slip_drop == $past(slip_event)))
        else $error("full write did not discard exactly on time");
    chk_event_sets_bit: assert property (@(posedge aclk)
        disable iff (!aresetn)
        slip_event |=> st.rx_full)
        else $error("slip full event lost");
    chk_read_clears: assert property (@(posedge aclk)
        disable iff (!aresetn)
        status_rd && !slip_event |=> !st.rx_full)
        else $error("status read did not clear sticky bit");
    chk_sticky_holds: assert property (@(posedge aclk)
        disable iff (!aresetn)
        st.rx_full && !status_rd && !status_clr |=> st.rx_full)
        else $error("sticky bit dropped without a clear");
    chk_cas_read_live: assert property (@(posedge aclk)
        disable iff (!aresetn)
        status_rd |=> s_axi_rdata[`E1RS_BIT_CAS_LOCK] == $past(cas_lock))
        else $error("status read shows stale CAS lock");
    chk_crc_read_live: assert property (@(posedge aclk)
        disable iff (!aresetn)
        status_rd |=> s_axi_rdata[`E1RS_BIT_CRC_LOCK] == $past(crc_lock))
        else $error("status read shows stale CRC lock");
    chk_irq_level: assert property (@(posedge aclk)
        disable iff (!aresetn)
        irq == (st.rx_full && st.mask_full))
        else $error("interrupt disagrees with status and mask");
endmodule

// ==== tb/tb.sv ====
// Purpose: self-checking bench for the sync and slip status bank
// Assumes: bus answers come whenever the slave is ready
// Notes:   each bus task starts one edge after the last one ended
module tb;
    timeunit 1ns;
    timeprecision 1ps;
`define CK(a, b) begin total_checks++; if ((a) !== (b)) begin \
num_errors++; $display("BAD %0t mismatch", $time); end end
    int          num_errors   = 0;  // mismatches
    int          total_checks = 0;  // comparisons
    logic        aclk, aresetn;     // clock, reset low
    logic [3:0]  aw_a, ar_a;        // bus addresses
    logic [31:0] w_d, r_d;          // bus data
    logic        aw_v, w_v, b_r, ar_v, r_r;   // bench handshakes
    logic        aw_r, w_r, b_v, ar_r, r_v;   // slave handshakes
    logic [1:0]  b_resp, r_resp;    // answer codes
    logic        cas_s, cas_k, crc_s, crc_k;  // alignment verdicts
    logic        sb_full, sb_wr, drop;        // slip buffer side
    logic        cas_l, crc_l, irq;           // status outputs
    e1rs_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw_a),
        .s_axi_awvalid(aw_v), .s_axi_awready(aw_r), .s_axi_wdata(w_d),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(w_v), .s_axi_wready(w_r),
        .s_axi_bresp(b_resp), .s_axi_bvalid(b_v), .s_axi_bready(b_r),
        .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_r),
        .s_axi_rdata(r_d), .s_axi_rresp(r_resp), .s_axi_rvalid(r_v),
        .s_axi_rready(r_r), .cas_align_stb(cas_s), .cas_align_ok(cas_k),
        .crc_align_stb(crc_s), .crc_align_ok(crc_k),
        .rx_slip_buf_full(sb_full), .rx_slip_wr(sb_wr),
        .rx_slip_drop(drop), .cas_mf_lock(cas_l),
        .crc_mf_lock_flag(crc_l), .irq(irq));
    // free running 100 MHz clock
    always #5 aclk = ~aclk;
    // write one word; address and data released as each is taken
    task wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] e);
        @(posedge aclk);
        aw_a <= a; w_d <= {24'h000000, d};
        aw_v <= 1'b1; w_v <= 1'b1; b_r <= 1'b1;
        fork
            begin do @(posedge aclk); while (!aw_r); aw_v <= 1'b0; end
            begin do @(posedge aclk); while (!w_r); w_v <= 1'b0; end
        join
        while (!b_v) @(posedge aclk);
        b_r <= 1'b0;
        `CK(b_resp, e)
    endtask
    // read one word; ev raises a slip event in the cycle the read is taken
    task rd(input logic [3:0] a, input logic [7:0] d, input logic [1:0] e,
            input logic ev);
        @(posedge aclk);
        ar_a <= a; ar_v <= 1'b1; r_r <= 1'b1; sb_full <= ev; sb_wr <= ev;
        do @(posedge aclk); while (!ar_r);
        ar_v <= 1'b0; sb_full <= 1'b0; sb_wr <= 1'b0;
        while (!r_v) @(posedge aclk);
        r_r <= 1'b0;
        `CK(r_d, {24'h000000, d})
        `CK(r_resp, e)
    endtask
    // one alignment verdict; lock is settled when this returns
    task al(input logic crc, input logic ok);
        @(posedge aclk);
        cas_s <= !crc; crc_s <= crc; cas_k <= ok; crc_k <= ok;
        @(posedge aclk);
        cas_s <= 1'b0; crc_s <= 1'b0;
        @(posedge aclk);
    endtask
    // slip buffer full for one cycle, with or without a write
    task sl(input logic w);
        @(posedge aclk);
        sb_full <= 1'b1; sb_wr <= w;
        @(posedge aclk);
        sb_full <= 1'b0; sb_wr <= 1'b0;
        @(posedge aclk);
    endtask
    // reset values and an unmapped address
    task t_reset;
        rd(4'h0, 8'h00, 2'h0, 1'b0);
        rd(4'h4, 8'h00, 2'h0, 1'b0);
        rd(4'hC, 8'h22, 2'h0, 1'b0);
        wr(4'h2, 8'hFF, 2'h2);
        rd(4'h2, 8'h00, 2'h2, 1'b0);
    endtask
    // lock on first good word, lost after two errors in a row
    task t_cas;
        al(1'b0, 1'b0); `CK(cas_l, 1'b0)
        al(1'b0, 1'b1); `CK(cas_l, 1'b1)
        rd(4'h0, 8'h10, 2'h0, 1'b0);
        al(1'b0, 1'b0); `CK(cas_l, 1'b1)
        al(1'b0, 1'b1);
        al(1'b0, 1'b0); `CK(cas_l, 1'b1)
        al(1'b0, 1'b0); `CK(cas_l, 1'b0)
        rd(4'h0, 8'h00, 2'h0, 1'b0);
    endtask
    // two good words needed, one error loses lock
    task t_crc;
        wr(4'h8, 8'h02, 2'h0);
        al(1'b1, 1'b1); `CK(crc_l, 1'b0)
        al(1'b1, 1'b1); `CK(crc_l, 1'b1)
        rd(4'h0, 8'h08, 2'h0, 1'b0);
        wr(4'hC, 8'h12, 2'h0);
        al(1'b1, 1'b0); `CK(crc_l, 1'b0)
        rd(4'h0, 8'h00, 2'h0, 1'b0);
    endtask
    // sticky full event: drop, interrupt, read clear, write clear
    task t_slip;
        sl(1'b0); `CK(drop, 1'b0)
        rd(4'h0, 8'h00, 2'h0, 1'b0);
        wr(4'h4, 8'h04, 2'h0);
        sl(1'b1); `CK(drop, 1'b1)
        `CK(irq, 1'b1)
        rd(4'h0, 8'h04, 2'h0, 1'b0);
        `CK(irq, 1'b0)
        rd(4'h0, 8'h00, 2'h0, 1'b0);
        sl(1'b1);
        wr(4'h0, 8'h04, 2'h0);
        rd(4'h0, 8'h00, 2'h0, 1'b0);
        rd(4'h0, 8'h00, 2'h0, 1'b1);
        rd(4'h0, 8'h04, 2'h0, 1'b0);
        wr(4'h4, 8'h00, 2'h0);
        sl(1'b1); `CK(irq, 1'b0)
    endtask
    // two-good CAS declaration, then a mid-run reset restores defaults
    task t_rst;
        wr(4'h8, 8'h01, 2'h0);
        wr(4'h4, 8'h04, 2'h0);
        al(1'b0, 1'b1); `CK(cas_l, 1'b0)
        al(1'b0, 1'b1); `CK(cas_l, 1'b1)
        `CK(irq, 1'b1)
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        `CK(irq, 1'b0)
        `CK(cas_l, 1'b0)
        rd(4'h0, 8'h00, 2'h0, 1'b0);
        rd(4'h8, 8'h00, 2'h0, 1'b0);
        rd(4'hC, 8'h22, 2'h0, 1'b0);
    endtask
    // verdict and end of run
    task summarize;
        if (num_errors == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // watchdog well past the 130 or so cycles the tests need
    initial begin
        #100000;
        num_errors++;
        summarize();
    end
    // main sequence
    initial begin
        aclk = 1'b0; aresetn = 1'b0; aw_a = 4'h0; ar_a = 4'h0; w_d = '0;
        {aw_v, w_v, b_r, ar_v, r_r} = 5'h00;
        {cas_s, cas_k, crc_s, crc_k, sb_full, sb_wr} = 6'h00;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_cas();
        t_crc();
        t_slip();
        t_rst();
        summarize();
    end
endmodule
